// ---- pkg/asra_params.svh ----
// constants of the serial register-access front end
// assumes inclusion by bare name from package and design files
`ifndef ASRA_PARAMS_SVH
`define ASRA_PARAMS_SVH

// command byte layout
`define ASRA_CMD_W 8
`define ASRA_CMD_WEN_BIT 7
`define ASRA_CMD_RW_BIT 6
`define ASRA_ADDR_W 6
`define ASRA_ADDR_MSB 5

// register offsets
`define ASRA_OFF_COMMAND 6'h00
`define ASRA_OFF_DATA 6'h04
`define ASRA_OFF_IDENT 6'h07
`define ASRA_OFF_CH0 6'h10
`define ASRA_OFF_SETUP0 6'h20
`define ASRA_OFF_OFFSET0 6'h30

// reset values
`define ASRA_RST_CH0 24'h008001
`define ASRA_RST_OTHER 24'h000000

// data phase lengths in bits
`define ASRA_LEN_8 6'h08
`define ASRA_LEN_16 6'h10
`define ASRA_LEN_24 6'h18
`define ASRA_LEN_32 6'h20

// storage and shifter widths
`define ASRA_REG_W 24
`define ASRA_SHIFT_W 32
`define ASRA_DEPTH 64

// full reset after this many rising edges with the data input high
`define ASRA_ONES_RESET 7'h40
`define ASRA_ONES_W 7

`endif

// ---- pkg/asra_pkg.sv ----
// types of the serial register-access front end
// assumes asra_params.svh is on the include path
package asra_pkg;
  `include "asra_params.svh"

  typedef enum logic [2:0] {
    ASRA_ST_CMD = 3'b001,
    ASRA_ST_WR = 3'b010,
    ASRA_ST_RD = 3'b100
  } asra_state_t;

  typedef logic [`ASRA_ADDR_W-1:0] asra_addr_t;
endpackage

// ---- hw/asra_sync.sv ----
// two-flop synchroniser for a group of asynchronous pin inputs
// assumes one destination clock; each bit is crossed on its own
`timescale 1ns/10ps
module asra_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
          meta_q <= INIT[i];
          sync_q <= INIT[i];
        end else if (ce_in) begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate
endmodule // asra_sync

// ---- hw/asra_spi.sv ----
// serial register-access front end of a multiplexed converter
// assumes a host driving sclk, din and chip select (or chip select tied low)
`timescale 1ns/10ps
`include "asra_params.svh"

module asra_spi #(
  parameter logic [15:0] IDENT_CODE = 16'h1234  // arbitrary value
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic sclk_in,
  input wire logic din_in,
  input wire logic cs_n_in,
  input wire logic [23:0] conv_data_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic dev_reset_out,
  output logic reg_wr_out,
  output asra_pkg::asra_addr_t reg_addr_out,
  output logic [23:0] reg_data_out
);
  import asra_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisation and edge detection
  // ---------------------------------------------------------------
  logic [2:0] pins_s;
  logic sclk_s;
  logic din_s;
  logic cs_n_s;
  logic sclk_prev_q;
  logic rise;
  logic fall;

  asra_sync #(
    .WIDTH(3),
    .INIT(3'h7)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in({sclk_in, din_in, cs_n_in}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign din_s = pins_s[1];
  assign cs_n_s = pins_s[0];

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sclk_prev_q <= 1'b1;  // idles high
    end else if (ce_in) begin
      sclk_prev_q <= sclk_s;
    end
  end

  // edges count only while selected; tied-low select is always selected
  assign rise = ce_in && !cs_n_s && sclk_s && !sclk_prev_q;  // sample edge
  assign fall = ce_in && !cs_n_s && !sclk_s && sclk_prev_q;  // drive edge

  // ---------------------------------------------------------------
  // full device reset by a run of ones
  // ---------------------------------------------------------------
  logic [`ASRA_ONES_W-1:0] ones_q;
  logic full_rst;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ones_q <= '0;
    end else if (ce_in) begin
      if (cs_n_s || full_rst) begin
        ones_q <= '0;
      end else if (rise) begin
        ones_q <= din_s ? ones_q + 1'b1 : '0;
      end
    end
  end

  assign full_rst = (ones_q == `ASRA_ONES_RESET);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dev_reset_out <= 1'b0;
    end else if (ce_in) begin
      dev_reset_out <= full_rst;
    end
  end

  // ---------------------------------------------------------------
  // register map helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] data_len(input asra_addr_t a, input logic rd);
    logic [5:0] len;
    len = `ASRA_LEN_8;
    if (a == `ASRA_OFF_DATA) begin
      len = rd ? `ASRA_LEN_32 : `ASRA_LEN_24;
    end else if (a == `ASRA_OFF_IDENT) begin
      len = `ASRA_LEN_16;
    end else if (a >= `ASRA_OFF_OFFSET0) begin
      len = `ASRA_LEN_24;
    end else if (a >= `ASRA_OFF_CH0) begin
      len = `ASRA_LEN_16;
    end
    return len;
  endfunction

  function automatic logic writable(input asra_addr_t a);
    return (a != `ASRA_OFF_COMMAND) && (a != `ASRA_OFF_DATA) && (a != `ASRA_OFF_IDENT);
  endfunction

  // ---------------------------------------------------------------
  // transaction state
  // ---------------------------------------------------------------
  asra_state_t state_q;
  logic [5:0] cnt_q;
  logic [5:0] len_q;
  asra_addr_t addr_q;
  logic [`ASRA_SHIFT_W-1:0] sin_q;
  logic [`ASRA_SHIFT_W-1:0] sout_q;
  logic [`ASRA_SHIFT_W-1:0] rd_word;
  logic [`ASRA_REG_W-1:0] regs_q [`ASRA_DEPTH];
  logic [`ASRA_CMD_W-1:0] cmd_byte;
  logic [`ASRA_REG_W-1:0] wr_word;
  logic last_bit;
  logic commit;

  assign cmd_byte = {sin_q[6:0], din_s};
  // short registers keep only their own bits, not the command byte
  assign wr_word = {sin_q[`ASRA_REG_W-2:0], din_s} & ~({`ASRA_REG_W{1'b1}} << len_q);
  assign last_bit = rise && (cnt_q + 6'h01 == len_q);
  assign commit = last_bit && (state_q == ASRA_ST_WR) && writable(addr_q);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || full_rst) begin
      state_q <= ASRA_ST_CMD;
      cnt_q <= '0;
      len_q <= `ASRA_LEN_8;
      addr_q <= '0;
    end else if (ce_in) begin
      if (cs_n_s) begin
        state_q <= ASRA_ST_CMD;  // abort, registers kept
        cnt_q <= '0;
        len_q <= `ASRA_LEN_8;
      end else if (rise) begin
        if (last_bit) begin
          cnt_q <= '0;
          case (state_q)
            ASRA_ST_CMD: begin
              if (!cmd_byte[`ASRA_CMD_WEN_BIT]) begin
                addr_q <= cmd_byte[`ASRA_ADDR_MSB:0];
                len_q <= data_len(cmd_byte[`ASRA_ADDR_MSB:0], cmd_byte[`ASRA_CMD_RW_BIT]);
                state_q <= cmd_byte[`ASRA_CMD_RW_BIT] ? ASRA_ST_RD : ASRA_ST_WR;
              end
            end
            default: begin
              state_q <= ASRA_ST_CMD;
              len_q <= `ASRA_LEN_8;
            end
          endcase
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // input shifter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sin_q <= '0;
    end else if (ce_in && rise) begin
      sin_q <= {sin_q[`ASRA_SHIFT_W-2:0], din_s};  // msb first
    end
  end

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `ASRA_DEPTH; gi++) begin : g_reg
      always_ff @(posedge sys_clk_in) begin
        if (rst_in || full_rst) begin
          regs_q[gi] <= (gi == `ASRA_OFF_CH0) ? `ASRA_RST_CH0 : `ASRA_RST_OTHER;
        end else if (ce_in && commit && (addr_q == 6'(gi))) begin
          regs_q[gi] <= wr_word;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read data, left aligned to the shifter msb
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    case (cmd_byte[`ASRA_ADDR_MSB:0])
      `ASRA_OFF_COMMAND: rd_word = {2'b00, addr_q, 24'h000000};  // state view, not the command
      `ASRA_OFF_DATA: rd_word = {conv_data_in, 2'b00, addr_q};
      `ASRA_OFF_IDENT: rd_word = {IDENT_CODE, 16'h0000};  // fixed code
      default: begin
        case (data_len(cmd_byte[`ASRA_ADDR_MSB:0], 1'b1))
          `ASRA_LEN_24: rd_word = {regs_q[cmd_byte[`ASRA_ADDR_MSB:0]], 8'h00};
          `ASRA_LEN_16: rd_word = {regs_q[cmd_byte[`ASRA_ADDR_MSB:0]][15:0], 16'h0000};
          default: rd_word = {regs_q[cmd_byte[`ASRA_ADDR_MSB:0]][7:0], 24'h000000};
        endcase
      end
    endcase
  end

  // ---------------------------------------------------------------
  // output shifter and pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || full_rst) begin
      sout_q <= '0;
      dout_out <= 1'b1;
    end else if (ce_in) begin
      if (cs_n_s) begin
        sout_q <= '0;
        dout_out <= 1'b1;
      end else if (rise && last_bit && (state_q == ASRA_ST_CMD)
                   && !cmd_byte[`ASRA_CMD_WEN_BIT] && cmd_byte[`ASRA_CMD_RW_BIT]) begin
        sout_q <= rd_word;
      end else if (fall) begin
        if (state_q == ASRA_ST_RD) begin
          dout_out <= sout_q[`ASRA_SHIFT_W-1];  // change on falling edge
          sout_q <= {sout_q[`ASRA_SHIFT_W-2:0], 1'b0};
        end else begin
          dout_out <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dout_oe_out <= 1'b0;
    end else if (ce_in) begin
      dout_oe_out <= !cs_n_s;
    end
  end

  // ---------------------------------------------------------------
  // write notification to the rest of the device
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_wr_out <= 1'b0;
      reg_addr_out <= '0;
      reg_data_out <= '0;
    end else if (ce_in) begin
      reg_wr_out <= commit;
      if (commit) begin
        reg_addr_out <= addr_q;
        reg_data_out <= wr_word;
      end
    end
  end
endmodule // asra_spi

// ---- test/asra_spi_assertions.sv ----
// port checker of the serial register-access front end
// assumes bind onto asra_spi, sclk half period of several clocks
`timescale 1ns/10ps
module asra_spi_assertions (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic dout_out,
  input wire logic dout_oe_out,
  input wire logic dev_reset_out,
  input wire logic reg_wr_out,
  input wire logic [5:0] reg_addr_out
);
  // ----
  // link rules
  // ----
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  oe_on_sel_a: assert property ((ce_in && !cs_n_in)[*5] |-> dout_oe_out)
    else $error("dout enable low while selected");
  oe_off_desel_a: assert property (cs_n_in[*4] |-> !dout_oe_out)
    else $error("dout enable high while deselected");
  dout_idle_a: assert property (cs_n_in[*6] |-> dout_out)
    else $error("dout not idle high");
  wr_pulse_a: assert property (reg_wr_out |=> !reg_wr_out)
    else $error("write strobe longer than one cycle");
  rst_pulse_a: assert property (dev_reset_out |=> !dev_reset_out && !reg_wr_out)
    else $error("device reset pulse wrong");
  ident_ro_a: assert property (reg_wr_out |-> !(reg_addr_out inside {6'h00, 6'h04, 6'h07}))
    else $error("write to read-only place");
  abort_quiet_a: assert property (cs_n_in[*8] |-> !reg_wr_out && !dev_reset_out)
    else $error("activity while deselected");
  quiet_link_a: assert property ($stable(sclk_in)[*8] |-> !reg_wr_out && !dev_reset_out)
    else $error("activity without sclk edges");
endmodule // asra_spi_assertions

bind asra_spi asra_spi_assertions u_chk (.sys_clk_in, .rst_in, .ce_in, .sclk_in, .cs_n_in, .dout_out,
  .dout_oe_out, .dev_reset_out, .reg_wr_out, .reg_addr_out);

// ---- test/asra_host.sv ----
// spi mode 3 host model driving the converter pins
// assumes hierarchical calls of xfer; 125 ns link period
`timescale 1ns/10ps
module asra_host (
  output logic sclk_out,
  output logic din_out,
  output logic cs_n_out,
  input wire logic dout_in
);
  // ----
  // frames
  // ----
  initial begin
    sclk_out = 1'b1;
    din_out = 1'b1;
    cs_n_out = 1'b1;
  end
  // msb first; keep leaves chip select low
  task automatic xfer(input logic [63:0] v, input int n, input bit keep, output logic [63:0] rd);
    rd = '0;
    cs_n_out = 1'b0;
    #62.5;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_out = 1'b0;
      din_out = v[i];
      #62.5;
      sclk_out = 1'b1;
      rd = {rd[62:0], dout_in};
      #62.5;
    end
    din_out = ~din_out;
    cs_n_out = !keep;
    #62.5;
  endtask
endmodule // asra_host

// ---- test/asra_spi_bench.sv ----
// self-checking bench of the serial register-access front end
// assumes asra_host on the pins and the bound checker
`timescale 1ns/10ps
module asra_spi_bench;
  localparam logic [15:0] IDENT = 16'h5a3c; // arbitrary value
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [23:0] conv_data_in = 24'h000000;
  logic sclk, din, cs_n, dout_out, dout_oe_out, dev_reset_out, reg_wr_out;
  logic [5:0] reg_addr_out;
  logic [5:0] a;
  logic [23:0] reg_data_out;
  logic [23:0] d;
  logic [23:0] mem [64];
  logic [63:0] rd;
  integer seed = 12;
  int n_errors = 0;
  int checks_done = 0;
  int n_wr = 0;
  int n_rst = 0;
  int n_frz = 0;
  // ----
  // harness
  // ----
  always #5 sys_clk_in = ~sys_clk_in;
  asra_spi #(.IDENT_CODE(IDENT)) dut (.sys_clk_in, .rst_in, .ce_in, .sclk_in(sclk), .din_in(din), .cs_n_in(cs_n),
    .conv_data_in, .dout_out, .dout_oe_out, .dev_reset_out, .reg_wr_out, .reg_addr_out, .reg_data_out);
  asra_host host (.sclk_out(sclk), .din_out(din), .cs_n_out(cs_n), .dout_in(dout_out));
  always @(posedge sys_clk_in) begin
    n_wr <= n_wr + int'(reg_wr_out === 1'b1);
    n_rst <= n_rst + int'(dev_reset_out === 1'b1);
  end
  function automatic int len(logic [5:0] x, bit r);
    if (x == 6'h04) return r ? 32 : 24;
    if (x == 6'h07 || x inside {[6'h10:6'h2f]}) return 16;
    return (x >= 6'h30) ? 24 : 8;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [5:0] x, logic [23:0] v, bit keep);
    int n0;
    bit ok;
    n0 = n_wr;
    ok = !(x inside {6'h00, 6'h04, 6'h07});
    v = v & ((24'h1 << len(x, 0)) - 24'h1);
    host.xfer(({58'h0, x} << len(x, 0)) | v, len(x, 0) + 8, keep, rd);
    repeat (8) @(posedge sys_clk_in);
    chk(n_wr - n0, ok);
    chk(dout_oe_out, keep);
    if (ok) begin
      chk(reg_addr_out, x);
      chk(reg_data_out, v);
      mem[x] = v;
    end
  endtask
  task automatic rdchk(logic [5:0] x, logic [31:0] exp, bit keep);
    host.xfer({56'h0, 2'b01, x} << len(x, 1), len(x, 1) + 8, keep, rd);
    rd = rd & ((64'h1 << len(x, 1)) - 64'h1);
    chk(rd[31:0], exp);
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #500000;
    n_errors++;
    end_of_test;
  end
  // ----
  // scenarios
  // ----
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = (i == 16) ? 24'h008001 : 24'h0;
    mem[7] = {8'h00, IDENT};
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    host.xfer('1, 64, 0, rd);
    repeat (8) @(posedge sys_clk_in);
    chk(n_rst, 1);
    rdchk(6'h07, IDENT, 0);
    wr(6'h07, 24'h00a5a5, 0);
    wr(6'h04, 24'h123456, 0);
    wr(6'h00, 24'h00005a, 0);
    rdchk(6'h10, 24'h008001, 0);
    repeat (14) begin
      a = $random(seed);
      d = $random(seed);
      if (a inside {6'h00, 6'h04}) a ^= 6'h20;
      wr(a, d, 0);
      rdchk(a, mem[a], 0);
    end
    n_frz = n_wr;
    ce_in <= 1'b0;
    @(posedge sys_clk_in);
    host.xfer({40'h0, 8'h22, 16'hc3c3}, 24, 0, rd);
    @(posedge sys_clk_in);
    ce_in <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    chk(n_wr - n_frz, 0);
    chk(dout_oe_out, 0);
    rdchk(6'h22, mem[6'h22], 0);
    @(posedge sys_clk_in);
    conv_data_in <= $random(seed);
    @(posedge sys_clk_in);
    host.xfer(64'h44 << 32, 40, 0, rd);
    chk(rd[31:8], conv_data_in);
    host.xfer(64'ha0, 8, 1, rd);
    chk(rd[7:0], 8'hff);
    rdchk(6'h07, IDENT, 0);
    host.xfer(64'h83, 10, 0, rd);
    wr(6'h21, 24'h00beef, 1);
    rdchk(6'h21, 24'h00beef, 1);
    rdchk(6'h07, IDENT, 0);
    host.xfer('1, 64, 0, rd);
    repeat (8) @(posedge sys_clk_in);
    chk(n_rst, 2);
    rdchk(6'h21, 24'h0, 0);
    rdchk(6'h10, 24'h008001, 0);
    end_of_test;
  end
endmodule // asra_spi_bench
